// File: rtl/ssf_status.sv
// status flags, configuration and interrupt logic of the serial port
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ssf_status
  import ssf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire ssf_event_t  events,
  input  wire ssf_level_t  levels,
  output logic             transferIntMode,
  output logic             receiveFlush,
  output logic             transmitFlush,
  output logic             dmaMode,
  output logic             irq
);

  // registers
  logic [2:0]  rxLevel_r;
  logic [2:0]  txLevel_r;
  logic        ovfFlag_r;
  logic        rxiFlag_r;
  logic        txiFlag_r;
  logic        undFlag_r;
  logic        sumFlag_r;
  logic [3:0]  config_r;
  logic [3:0]  irqStatus_r;
  logic [3:0]  irqMask_r;
  logic        ack_r;
  logic        err_r;
  logic [31:0] rdData_r;

  // next values of the registers
  logic [2:0]  rxLevel_nxt;
  logic [2:0]  txLevel_nxt;
  logic        ovfFlag_nxt;
  logic        rxiFlag_nxt;
  logic        txiFlag_nxt;
  logic        undFlag_nxt;
  logic        sumFlag_nxt;
  logic [3:0]  config_nxt;
  logic [3:0]  irqStatus_nxt;
  logic [3:0]  irqMask_nxt;
  logic        irq_nxt;
  logic        ack_nxt;
  logic        err_nxt;
  logic [31:0] rdData_nxt;

  // bus decode
  logic        busReq;
  logic        selStatus;
  logic        selConfig;
  logic        selIrqSt;
  logic        selIrqMsk;
  logic        hit;
  logic        wrCfg;
  logic        wrIrqSt;
  logic        wrIrqMsk;
  logic        rdStatus;
  logic        rdAny;
  logic [3:0]  irqClear;

  // flag conditions
  logic        setOvf;
  logic        setRxi;
  logic        setTxi;
  logic        setUnd;
  logic        intOvf;
  logic        intUnd;
  logic        setSum;
  logic [3:0]  irqEvt;
  logic [15:0] statusView;

  // one access per request; ack drops the cycle after it is given
  assign busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign selStatus = (wb_adr_i == SSF_ADDR_STATUS);
  assign selConfig = (wb_adr_i == SSF_ADDR_CONFIG);
  assign selIrqSt  = (wb_adr_i == SSF_ADDR_IRQST);
  assign selIrqMsk = (wb_adr_i == SSF_ADDR_IRQMSK);
  assign hit       = selStatus | selConfig | selIrqSt | selIrqMsk;
  // only the low byte lane holds writable bits
  assign wrCfg     = busReq & wb_we_i & wb_sel_i[0] & selConfig;
  assign wrIrqSt   = busReq & wb_we_i & wb_sel_i[0] & selIrqSt;
  assign wrIrqMsk  = busReq & wb_we_i & wb_sel_i[0] & selIrqMsk;
  assign rdStatus  = busReq & ~wb_we_i & selStatus;
  assign rdAny     = busReq & ~wb_we_i;
  assign irqClear  = wrIrqSt ? wb_dat_i[3:0] : 4'h0;

  assign transferIntMode = config_r[SSF_POS_TIM];
  assign receiveFlush    = config_r[SSF_POS_RECEIVE_FLUSH];
  assign transmitFlush   = config_r[SSF_POS_TRANSMIT_FLUSH];
  assign dmaMode         = config_r[SSF_POS_DMA];

  // fill codes beyond four are clipped; the fifo never holds more
  always_comb begin
    rxLevel_nxt = levels.rxLevel;
    if (levels.rxLevel > SSF_LEVEL_FOUR) begin
      rxLevel_nxt = SSF_LEVEL_FOUR;
    end
  end

  always_comb begin
    txLevel_nxt = levels.txLevel;
    if (levels.txLevel > SSF_LEVEL_FOUR) begin
      txLevel_nxt = SSF_LEVEL_FOUR;
    end
  end

  // overflow looks at the level as it stands now, not at the registered copy
  assign setOvf = events.rxByte & (rxLevel_nxt == SSF_LEVEL_FOUR);
  assign setRxi = events.rxThresh & ~transferIntMode & ~dmaMode;
  assign setTxi = events.txThresh & transferIntMode & ~dmaMode;
  assign setUnd = events.txUnderrun;
  // flushes silence the interrupt only; the flag still records the event
  assign intOvf = setOvf & ~receiveFlush;
  assign intUnd = setUnd & ~transmitFlush;
  assign setSum = intOvf | setRxi | setTxi | intUnd;
  assign irqEvt = {intUnd, setTxi, setRxi, intOvf};

  // sticky flags: a set in the cycle of a status read wins over its clear
  always_comb begin
    ovfFlag_nxt = setOvf | (ovfFlag_r & ~rdStatus);
    rxiFlag_nxt = setRxi | (rxiFlag_r & ~rdStatus);
    txiFlag_nxt = setTxi | (txiFlag_r & ~rdStatus);
    undFlag_nxt = setUnd | (undFlag_r & ~rdStatus);
    sumFlag_nxt = setSum | (sumFlag_r & ~rdStatus);
  end

  // levels follow the fifo every cycle; a read never touches them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxLevel_r <= SSF_RST_STATUS[SSF_POS_RXLV +: 3];
      txLevel_r <= SSF_RST_STATUS[SSF_POS_TXLV +: 3];
    end else begin
      rxLevel_r <= rxLevel_nxt;
      txLevel_r <= txLevel_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovfFlag_r <= SSF_RST_STATUS[SSF_POS_RECEIVE_OVERFLOW_FLAG];
    end else begin
      ovfFlag_r <= ovfFlag_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxiFlag_r <= SSF_RST_STATUS[SSF_POS_RXI];
    end else begin
      rxiFlag_r <= rxiFlag_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txiFlag_r <= SSF_RST_STATUS[SSF_POS_TXI];
    end else begin
      txiFlag_r <= txiFlag_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      undFlag_r <= SSF_RST_STATUS[SSF_POS_TRANSMIT_UNDERRUN_FLAG];
    end else begin
      undFlag_r <= undFlag_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sumFlag_r <= SSF_RST_STATUS[SSF_POS_IRQ];
    end else begin
      sumFlag_r <= sumFlag_nxt;
    end
  end

  // status word as software sees it; bits above the receive level read zero
  always_comb begin
    statusView                    = 16'h0000;
    statusView[SSF_POS_IRQ]       = sumFlag_r;
    statusView[SSF_POS_TXLV +: 3] = txLevel_r;
    statusView[SSF_POS_TRANSMIT_UNDERRUN_FLAG]      = undFlag_r;
    statusView[SSF_POS_TXI]       = txiFlag_r;
    statusView[SSF_POS_RXI]       = rxiFlag_r;
    statusView[SSF_POS_RECEIVE_OVERFLOW_FLAG]      = ovfFlag_r;
    statusView[SSF_POS_RXLV +: 3] = rxLevel_r;
  end

  always_comb begin
    config_nxt = config_r;
    if (wrCfg) begin
      config_nxt = wb_dat_i[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      config_r <= SSF_RST_CONFIG;
    end else begin
      config_r <= config_nxt;
    end
  end

  // interrupt status: write one to clear, a new event wins
  always_comb begin
    irqStatus_nxt = irqEvt | (irqStatus_r & ~irqClear);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus_r <= SSF_RST_IRQ;
    end else begin
      irqStatus_r <= irqStatus_nxt;
    end
  end

  always_comb begin
    irqMask_nxt = irqMask_r;
    if (wrIrqMsk) begin
      irqMask_nxt = wb_dat_i[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_r <= SSF_RST_IRQ;
    end else begin
      irqMask_r <= irqMask_nxt;
    end
  end

  // registered so the pin cannot glitch while status and mask settle
  always_comb begin
    irq_nxt = |(irqStatus_r & irqMask_r);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // a mapped address answers with ack, any other with err, never both
  always_comb begin
    ack_nxt = busReq & hit;
    err_nxt = busReq & ~hit;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // captured on the taking edge, so a status read returns the pre-clear flags
  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (rdAny) begin
      unique case (wb_adr_i)
        SSF_ADDR_STATUS: rdData_nxt = {16'h0000, statusView};
        SSF_ADDR_CONFIG: rdData_nxt = {28'h0000000, config_r};
        SSF_ADDR_IRQST:  rdData_nxt = {28'h0000000, irqStatus_r};
        SSF_ADDR_IRQMSK: rdData_nxt = {28'h0000000, irqMask_r};
        default:         rdData_nxt = 32'h0000_0000;
      endcase
    end
  end

  // data stands only with ack; zero otherwise keeps idle cycles harmless
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 32'h0000_0000;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdData_r;

endmodule : ssf_status
`default_nettype wire

// File: rtl/ssf_pkg.sv
// package for the serial port status flag block
package ssf_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [7:0] SSF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] SSF_ADDR_CONFIG = 8'h04;
  localparam logic [7:0] SSF_ADDR_IRQST  = 8'h08;
  localparam logic [7:0] SSF_ADDR_IRQMSK = 8'h0C;

  // status field positions
  localparam int SSF_POS_IRQ  = 0;
  localparam int SSF_POS_TXLV = 1;
  localparam int SSF_POS_TRANSMIT_UNDERRUN_FLAG = 4;
  localparam int SSF_POS_TXI  = 5;
  localparam int SSF_POS_RXI  = 6;
  localparam int SSF_POS_RECEIVE_OVERFLOW_FLAG = 7;
  localparam int SSF_POS_RXLV = 8;

  // configuration field positions
  localparam int SSF_POS_TIM    = 0;
  localparam int SSF_POS_RECEIVE_FLUSH = 1;
  localparam int SSF_POS_TRANSMIT_FLUSH = 2;
  localparam int SSF_POS_DMA    = 3;

  // reset values
  localparam logic [15:0] SSF_RST_STATUS = 16'h0000;
  localparam logic [3:0]  SSF_RST_CONFIG = 4'h0;
  localparam logic [3:0]  SSF_RST_IRQ    = 4'h0;

  // fifo level codes
  localparam logic [2:0] SSF_LEVEL_EMPTY = 3'h0;
  localparam logic [2:0] SSF_LEVEL_ONE   = 3'h1;
  localparam logic [2:0] SSF_LEVEL_TWO   = 3'h2;
  localparam logic [2:0] SSF_LEVEL_THREE = 3'h3;
  localparam logic [2:0] SSF_LEVEL_FOUR  = 3'h4;

  // events from the data path of the port
  typedef struct packed {
    logic rxByte;     // a byte is written into the receive fifo
    logic rxThresh;   // configured receive count reached
    logic txThresh;   // configured transmit count reached
    logic txUnderrun; // transmit fifo underran
  } ssf_event_t;

  typedef struct packed {
    logic [2:0] rxLevel;
    logic [2:0] txLevel;
  } ssf_level_t;
endpackage : ssf_pkg

// File: verif/ssf_status_monitor.sv
// checker bound to the status flag block
`timescale 1ns/1ps
`default_nettype none
module ssf_status_monitor
  import ssf_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire ssf_level_t  levels,
  input wire logic        transferIntMode,
  input wire logic        receiveFlush,
  input wire logic        transmitFlush,
  input wire logic        dmaMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic       tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic       mp = wb_adr_i[7:4] == 4'h0 && wb_adr_i[1:0] == 2'h0;
  wire logic       wr = wb_ack_o && wb_we_i;
  wire logic [3:0] cf = {dmaMode, transmitFlush, receiveFlush, transferIntMode};
  a_ack_mapped: assert property (tk && mp |=> wb_ack_o) else $error("no ack");
  a_err_unmapped: assert property (tk && !mp |=> wb_err_o && !wb_ack_o) else $error("no err");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  // fifo counts above four read back as four
  a_level_fields: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SSF_ADDR_STATUS |->
    wb_dat_o[10:8] == ($past(levels.rxLevel, 2) > 3'h4 ? 3'h4 : $past(levels.rxLevel, 2)) &&
    wb_dat_o[3:1] == ($past(levels.txLevel, 2) > 3'h4 ? 3'h4 : $past(levels.txLevel, 2))) else $error("level");
  a_cfg_write: assert property (wr && wb_adr_i == SSF_ADDR_CONFIG && wb_sel_i[0] |-> cf == wb_dat_i[3:0])
    else $error("config not written");
  a_cfg_gated: assert property (wr && !wb_sel_i[0] |-> $stable(cf)) else $error("config changed");
  cover property (wb_ack_o && wb_dat_o[7]);
  cover property (wb_err_o);
  cover property (wr && cf[3]);
endmodule : ssf_status_monitor
bind ssf_status ssf_status_monitor u_mon (.*);
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssf_pkg::*;
  logic        ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, err, tim, rfl, tfl, dma, irq;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wd = 0, rd, q;
  logic [15:0] rnd = 16'h9975;
  ssf_event_t  ev = '0;
  ssf_level_t  lv = '0;
  int          errors = 0, n_checks = 0, i;
  logic [1:0]  f, rs;
  ssf_status dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .events(ev), .levels(lv),
    .transferIntMode(tim), .receiveFlush(rfl), .transmitFlush(tfl), .dmaMode(dma), .irq(irq));
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [31:0] st(input logic [2:0] r, t, input logic [4:0] g);
    return {21'h0, r, g[4:1], t, g[0]};
  endfunction : st
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // an event may ride on the request so it lands on the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] e = 0, s = 4'hF);
    int k;
    k = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wd, ev, sel} <= {2'b11, w, a, d, e, s};
    do begin
      @(posedge ref_clk);
      ev <= '0;
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    if (ack !== 1'b1 && err !== 1'b1) begin
      errors++;
      test_done;
    end
    rs = {err, ack};
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask : bus
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1;
    bus(0, SSF_ADDR_STATUS, 0);
    chk(st(0, 0, 0), q);
    chk(32'h1, {30'h0, rs});
    for (i = 0; i <= 4; i++) begin
      rnd = lfsr(rnd);
      lv <= {3'(i), 3'(rnd % 5)};
      bus(0, SSF_ADDR_STATUS, {16'h0, rnd});
      chk(st(3'(i), 3'(rnd % 5), 0), q);
    end
    lv <= {3'h7, 3'h5};
    bus(0, SSF_ADDR_STATUS, 0);
    chk(st(3'h4, 3'h4, 5'h00), q);
    $display("levels done");
    lv <= {3'h4, 3'h0};
    for (i = 0; i < 4; i++) begin
      f = 2'(i);
      bus(1, SSF_ADDR_CONFIG, {29'h0, f[1], f[1], 1'b0});
      bus(1, SSF_ADDR_IRQMSK, 0);
      bus(1, SSF_ADDR_IRQST, 32'hF);
      bus(0, SSF_ADDR_STATUS, 0);
      bus(1, SSF_ADDR_STATUS, 32'hFFFF, f[0] ? 4'h1 : 4'h8);
      chk(32'h0, {31'h0, irq});
      bus(1, SSF_ADDR_IRQMSK, 32'hF);
      repeat (2) @(negedge ref_clk);
      chk({31'h0, !f[1]}, {31'h0, irq});
      bus(0, SSF_ADDR_STATUS, 0);
      chk(st(4, 0, {!f[0], 2'b0, f[0], !f[1]}), q);
      bus(0, SSF_ADDR_STATUS, 0);
      chk(st(4, 0, 0), q);
      bus(1, SSF_ADDR_IRQST, 32'hF);
      repeat (2) @(negedge ref_clk);
      chk(32'h0, {31'h0, irq});
    end
    $display("errors done");
    for (i = 0; i < 4; i++) begin
      f = 2'(i);
      bus(1, SSF_ADDR_CONFIG, {28'h0, f[1], 2'b0, f[0]});
      bus(1, SSF_ADDR_STATUS, 0, 4'h6);
      bus(0, SSF_ADDR_STATUS, 0);
      chk(st(4, 0, {1'b0, !f[0] && !f[1], f[0] && !f[1], 1'b0, !f[1]}), q);
    end
    bus(0, SSF_ADDR_STATUS, 0, 4'h1);
    chk(st(4, 0, 0), q);
    bus(0, SSF_ADDR_STATUS, 0);
    chk(st(4, 0, 5'h03), q);
    bus(1, SSF_ADDR_CONFIG, 0, 0, 4'hE);
    bus(0, 8'h10, 0);
    chk(32'h2, {30'h0, rs});
    chk(32'h0, q);
    chk(32'h9, {28'h0, dma, tfl, rfl, tim});
    $display("modes done");
    test_done;
  end
endmodule : tb_top
`default_nettype wire
